// >>> rtl/pfds_pkg.sv
// constants and types of the frame data service between a MAC and the PHY
// assumes a single 100 MHz clock domain; included by every file of the block
// What this block does
// - in transmit-enabled state, build a physical frame around payload, then send it.
// - after transmission fully completes, report success status to the MAC.
// - in receive-enabled or off state, do not transmit; return that state's code.
// - exactly one completion status for every accepted transmit request.
// - each received frame goes to MAC with count, payload and 8-bit quality.
// - received frames of zero length or above max_frame_octets are dropped.
// - state codes: receive-enabled 0x06, off 0x08, transmit-enabled 0x09.
// - refused state change codes: 0x01 while receiving, 0x02 while transmitting.
// - channel assessment codes: busy 0x00, idle 0x04.
// - forced switch-off code 0x03, success code 0x07.
// - attribute errors: out of range 0x05, unknown attribute 0x0A.
package pfds_pkg;

  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int unsigned MAX_FRAME_OCTETS = 127;
  localparam int unsigned COUNT_W          = 7;
  localparam logic [2:0]  MAX_COLOR_BAND   = 3'h6;
  localparam logic [7:0]  PREAMBLE_OCTET   = 8'hAA;  // framing octet sent before the header
  localparam int unsigned BUF_DEPTH        = 2;

  // ****************************************************************
  // status and enumeration codes
  // ****************************************************************
  typedef logic [3:0] pfds_status_t;
  localparam pfds_status_t CODE_BUSY_CHANNEL = 4'h0;
  localparam pfds_status_t CODE_BUSY_RX      = 4'h1;
  localparam pfds_status_t CODE_BUSY_TX      = 4'h2;
  localparam pfds_status_t CODE_FORCED_OFF   = 4'h3;
  localparam pfds_status_t CODE_IDLE_CHANNEL = 4'h4;
  localparam pfds_status_t CODE_BAD_PARAM    = 4'h5;
  localparam pfds_status_t CODE_RX_ON        = 4'h6;
  localparam pfds_status_t CODE_SUCCESS      = 4'h7;
  localparam pfds_status_t CODE_XCVR_OFF     = 4'h8;
  localparam pfds_status_t CODE_TX_ON        = 4'h9;
  localparam pfds_status_t CODE_UNKNOWN_ATTR = 4'hA;

  // transceiver state as given by the state-control block outside
  typedef enum logic [1:0] {
    PFDS_XCVR_OFF = 2'h0,
    PFDS_RX_ON   = 2'h1,
    PFDS_TX_ON   = 2'h2
  } pfds_trx_t;

  // ****************************************************************
  // transmit sequencer states
  // ****************************************************************
  typedef enum logic [4:0] {
    TX_IDLE     = 5'h01,
    TX_PREAMBLE = 5'h02,
    TX_HEADER   = 5'h04,
    TX_PAYLOAD  = 5'h08,
    TX_CONFIRM  = 5'h10
  } pfds_txst_t;

  // receive sequencer states
  typedef enum logic [3:0] {
    RX_IDLE    = 4'h1,
    RX_DELIVER = 4'h2,
    RX_DROP    = 4'h4,
    RX_DONE    = 4'h8
  } pfds_rxst_t;

  // true when a count is a legal received frame length
  function automatic logic len_ok(input logic [COUNT_W-1:0] n);
    len_ok = (n != '0) && (32'(n) <= MAX_FRAME_OCTETS);
  endfunction : len_ok

endpackage : pfds_pkg

// >>> rtl/pfds_buffer.sv
// two-entry octet buffer with valid/ready on both sides
// assumes one clock; full stalls the writer through inReady
`timescale 1ns/1ps
module pfds_buffer (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [7:0] inData,
  input  wire logic       inValid,
  output logic            inReady,
  output logic [7:0]      outData,
  output logic            outValid,
  input  wire logic       outReady
);

  typedef struct packed {
    logic [1:0][7:0] mem;
    logic            wrPtr;
    logic            rdPtr;
    logic [1:0]      fill;
  } pfds_buf_t;

  pfds_buf_t st;
  pfds_buf_t next_st;
  logic      doWrite;
  logic      doRead;

  // handshakes are combinational, the data word comes from a flip-flop
  assign inReady  = (st.fill != 2'(pfds_pkg::BUF_DEPTH));
  assign outValid = (st.fill != 2'h0);
  assign outData  = st.mem[st.rdPtr];
  assign doWrite  = inValid && inReady;
  assign doRead   = outValid && outReady;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    next_st = st;
    if (doWrite) begin
      next_st.mem[st.wrPtr] = inData;
      next_st.wrPtr         = ~st.wrPtr;
    end
    if (doRead) begin
      next_st.rdPtr = ~st.rdPtr;
    end
    next_st.fill = st.fill + 2'(doWrite) - 2'(doRead);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule : pfds_buffer

// >>> rtl/pfds_frame_data_service.sv
// frame data service: transmit requests from the MAC to the line, received frames back
// assumes the transceiver state comes from a state-control block, and line ports are octet streams
`timescale 1ns/1ps
module pfds_frame_data_service (
  input  wire logic                              clk,
  input  wire logic                              sys_rst,
  // transceiver state from the state-control block
  input  wire pfds_pkg::pfds_trx_t               trxState,
  // transmit request from the MAC
  input  wire logic                              txReqValid,
  output logic                                   txReqReady,
  input  wire logic [pfds_pkg::COUNT_W-1:0]      frameOctetCount,
  input  wire logic [2:0]                        colorBandSelect,
  input  wire logic [7:0]                        txOctet,
  input  wire logic                              txOctetValid,
  output logic                                   txOctetReady,
  output logic                                   txConfirm,
  output pfds_pkg::pfds_status_t                 txStatus,
  // octet stream toward the modulator
  output logic [7:0]                             lineTxData,
  output logic                                   lineTxValid,
  input  wire logic                              lineTxReady,
  output logic [2:0]                             lineColorBand,
  output logic                                   lineTxBusy,
  // received frame from the demodulator
  input  wire logic                              lineRxStart,
  input  wire logic [pfds_pkg::COUNT_W-1:0]      lineRxCount,
  input  wire logic [7:0]                        lineRxQuality,
  input  wire logic [7:0]                        lineRxData,
  input  wire logic                              lineRxValid,
  output logic                                   lineRxReady,
  // received frame toward the MAC
  output logic                                   rxIndValid,
  input  wire logic                              rxIndReady,
  output logic [pfds_pkg::COUNT_W-1:0]           rxOctetCount,
  output logic [7:0]                             rxQualityValue,
  output logic [7:0]                             rxOctet,
  output logic                                   rxOctetValid,
  input  wire logic                              rxOctetReady
);

  // all state in one record, transmit half first
  // txLeft: payload octets still owed by the MAC
  // rxLeft: line octets still due in this frame
  typedef struct packed {
    pfds_pkg::pfds_txst_t         txSt;
    logic [pfds_pkg::COUNT_W-1:0] txLeft;
    logic [pfds_pkg::COUNT_W-1:0] txCount;
    logic [2:0]                   band;
    logic                         confirm;
    pfds_pkg::pfds_status_t       status;
    pfds_pkg::pfds_rxst_t         rxSt;
    logic [pfds_pkg::COUNT_W-1:0] rxLeft;
    logic [pfds_pkg::COUNT_W-1:0] rxCount;
    logic [7:0]                   quality;
    logic                         indValid;
    logic [7:0]                   hdr;
    logic                         hdrValid;
  } pfds_state_t;

  pfds_state_t st;
  pfds_state_t next_st;

  // line frame: preamble, length header, payload
  // header low seven bits hold the count
  // header top bit is spare and always low
  // a line stall holds the octet where it is
  // busy spans preamble to the last payload octet
  // success confirm trails the last octet by three
  // cycles, so no octet is still held by then
  // a refused request leaves the line untouched;
  // only the state code goes back, a cycle later
  // the band is latched with the request and
  // stays steady for the whole frame

  logic       bufInReady;
  logic [7:0] bufOutData;
  logic       bufOutValid;
  logic       bufOutReady;
  logic       bufInValid;
  logic       payloadTake;
  logic       rxBufInReady;

  // shared octet countdown of both sequencers
  function automatic logic [pfds_pkg::COUNT_W-1:0] count_down(input logic [pfds_pkg::COUNT_W-1:0] n);
    count_down = n - 1'b1;
  endfunction : count_down

  // true while the last octet of a frame is due
  function automatic logic is_last(input logic [pfds_pkg::COUNT_W-1:0] n);
    is_last = (n == 7'h01);
  endfunction : is_last

  // ****************************************************************
  // transmit octet buffer
  // ****************************************************************
  // a stall by the modulator fills this buffer and then stalls the MAC
  // octets are let in only in the payload phase
  // and only while the count is open, so extra
  // octets from the MAC are held off, not lost
  assign bufInValid   = (st.txSt == pfds_pkg::TX_PAYLOAD) && txOctetValid && (st.txLeft != '0);
  assign txOctetReady = (st.txSt == pfds_pkg::TX_PAYLOAD) && bufInReady && (st.txLeft != '0);
  assign payloadTake  = bufInValid && bufInReady;

  // preamble and header bypass it via the header slot
  pfds_buffer u_tx_buf (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .inData   (txOctet),
    .inValid  (bufInValid),
    .inReady  (bufInReady),
    .outData  (bufOutData),
    .outValid (bufOutValid),
    .outReady (bufOutReady)
  );

  // header and preamble octets go out ahead of the buffered payload
  assign lineTxValid = st.hdrValid || (!st.hdrValid && bufOutValid);
  assign lineTxData  = st.hdrValid ? st.hdr : bufOutData;
  assign bufOutReady = !st.hdrValid && lineTxReady;
  assign lineColorBand = st.band;
  assign lineTxBusy    = (st.txSt != pfds_pkg::TX_IDLE) && (st.txSt != pfds_pkg::TX_CONFIRM);

  // a request is taken only while idle and the previous confirm is gone
  // ready stays low through the confirm: one status per request
  assign txReqReady = (st.txSt == pfds_pkg::TX_IDLE) && !st.confirm;
  assign txConfirm  = st.confirm;
  assign txStatus   = st.status;

  // ****************************************************************
  // receive octet buffer
  // ****************************************************************
  // line octets wait until the MAC takes the indication,
  // so count and quality arrive ahead of the payload
  assign lineRxReady  = (st.rxSt == pfds_pkg::RX_DROP) ||
                        ((st.rxSt == pfds_pkg::RX_DELIVER) && !st.indValid && rxBufInReady);

  // absorbs MAC stalls on rxOctetReady; once full,
  // lineRxReady drops and the line waits
  pfds_buffer u_rx_buf (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .inData   (lineRxData),
    .inValid  (lineRxValid && (st.rxSt == pfds_pkg::RX_DELIVER) && !st.indValid),
    .inReady  (rxBufInReady),
    .outData  (rxOctet),
    .outValid (rxOctetValid),
    .outReady (rxOctetReady)
  );

  // indication fields stay until the next frame start
  assign rxIndValid     = st.indValid;
  assign rxOctetCount   = st.rxCount;
  assign rxQualityValue = st.quality;

  // ****************************************************************
  // sequencers
  // ****************************************************************
  // one pass works out both sequencers
  // transmit: idle, preamble, header, payload, confirm
  // receive: idle, deliver then done, or drop back to idle
  // the header slot clears on a line handshake;
  // a state that refills it in the same cycle wins
  // confirm defaults low, so it lasts one cycle
  // and the status moves only with a new confirm
  always_comb begin
    next_st = st;
    // confirm strobe defaults low each cycle, so it lasts one cycle with no handshake from the MAC
    next_st.confirm = 1'b0;
    if (st.hdrValid && lineTxReady) begin
      next_st.hdrValid = 1'b0;
    end
    if (payloadTake) begin
      next_st.txLeft = count_down(st.txLeft);
    end
    case (st.txSt)
      pfds_pkg::TX_IDLE: begin
        if (txReqValid && txReqReady) begin
          if (trxState == pfds_pkg::PFDS_TX_ON) begin
            next_st.txSt    = pfds_pkg::TX_PREAMBLE;
            next_st.txCount = frameOctetCount;
            next_st.txLeft  = frameOctetCount;
            next_st.band    = (colorBandSelect > pfds_pkg::MAX_COLOR_BAND) ?
                              pfds_pkg::MAX_COLOR_BAND : colorBandSelect;
            next_st.hdr      = pfds_pkg::PREAMBLE_OCTET;
            next_st.hdrValid = 1'b1;
          end else begin
            // refused: nothing goes on the line, the state code answers
            next_st.confirm = 1'b1;
            next_st.status  = (trxState == pfds_pkg::PFDS_RX_ON) ?
                              pfds_pkg::CODE_RX_ON : pfds_pkg::CODE_XCVR_OFF;
          end
        end
      end

      pfds_pkg::TX_PREAMBLE: begin
        // swap the preamble for the length header
        if (st.hdrValid && lineTxReady) begin
          next_st.hdr      = {1'b0, st.txCount};                // length header
          next_st.hdrValid = 1'b1;
          next_st.txSt     = pfds_pkg::TX_HEADER;
        end
      end

      pfds_pkg::TX_HEADER: begin
        // payload phase opens once the header leaves
        if (st.hdrValid && lineTxReady) begin
          next_st.txSt = pfds_pkg::TX_PAYLOAD;
        end
      end

      pfds_pkg::TX_PAYLOAD: begin
        // done only after every octet has left the buffer toward the line
        if (st.txLeft == '0 && !bufOutValid) begin
          next_st.txSt = pfds_pkg::TX_CONFIRM;
        end
      end

      pfds_pkg::TX_CONFIRM: begin
        // one strobe, one code, back to idle
        next_st.confirm = 1'b1;
        next_st.status  = pfds_pkg::CODE_SUCCESS;
        next_st.txSt    = pfds_pkg::TX_IDLE;
      end
      default: begin
        next_st.txSt = pfds_pkg::TX_IDLE;
      end
    endcase

    case (st.rxSt)
      pfds_pkg::RX_IDLE: begin
        if (lineRxStart) begin
          next_st.rxCount = lineRxCount;
          next_st.rxLeft  = lineRxCount;
          next_st.quality = lineRxQuality;
          if (pfds_pkg::len_ok(lineRxCount)) begin
            next_st.rxSt     = pfds_pkg::RX_DELIVER;
            next_st.indValid = 1'b1;
          end else begin
            next_st.rxSt = (lineRxCount == '0) ? pfds_pkg::RX_IDLE : pfds_pkg::RX_DROP;
          end
        end
      end

      pfds_pkg::RX_DELIVER: begin
        // the MAC must take the indication before any octet goes in
        if (st.indValid && rxIndReady) begin
          next_st.indValid = 1'b0;
        end
        if (lineRxValid && lineRxReady) begin
          next_st.rxLeft = count_down(st.rxLeft);
          if (is_last(st.rxLeft)) begin
            next_st.rxSt = pfds_pkg::RX_DONE;
          end
        end
      end

      pfds_pkg::RX_DROP: begin
        // oversize frame: octets are swallowed and never reach the MAC
        if (lineRxValid) begin
          next_st.rxLeft = count_down(st.rxLeft);
          if (is_last(st.rxLeft)) begin
            next_st.rxSt = pfds_pkg::RX_IDLE;
          end
        end
      end

      pfds_pkg::RX_DONE: begin
        if (!rxOctetValid) begin
          next_st.rxSt = pfds_pkg::RX_IDLE;
        end
      end
      default: begin
        next_st.rxSt = pfds_pkg::RX_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  // reset: both sequencers idle, success as the
  // last code so an early status read shows no error;
  // only constants are loaded here
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st        <= '0;
      st.txSt   <= pfds_pkg::TX_IDLE;
      st.rxSt   <= pfds_pkg::RX_IDLE;
      st.status <= pfds_pkg::CODE_SUCCESS;
    end else begin
      st <= next_st;
    end
  end

  // limits a user must know:
  // - one request at a time, the next from the
  //   cycle after the confirm
  // - a seven-bit count cannot reach the drop path;
  //   it guards a wider count only
  // - a frame start during a frame is ignored
  // - a band above the top one is clipped, not refused
  // - the quality value is passed on as given

endmodule : pfds_frame_data_service

// >>> tb/pfds_checker.sv
// port checker for the frame data service
// assumes a bind onto the top module; one clock, async reset
`timescale 1ns/1ps
module pfds_checker (
  input wire logic                   clk,
  input wire logic                   sys_rst,
  input wire pfds_pkg::pfds_trx_t    trxState,
  input wire logic                   txReqValid,
  input wire logic                   txReqReady,
  input wire logic                   txConfirm,
  input wire pfds_pkg::pfds_status_t txStatus,
  input wire logic [7:0]             lineTxData,
  input wire logic                   lineTxValid,
  input wire logic                   lineTxReady,
  input wire logic                   lineRxStart,
  input wire logic [6:0]             lineRxCount,
  input wire logic [7:0]             lineRxQuality,
  input wire logic                   rxIndValid,
  input wire logic [6:0]             rxOctetCount,
  input wire logic [7:0]             rxQualityValue,
  input wire logic [7:0]             rxOctet,
  input wire logic                   rxOctetValid,
  input wire logic                   rxOctetReady
);
  // ****************
  // port properties
  // ****************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // a request taken while the transmitter is enabled
  sequence s_acc; txReqValid && txReqReady && trxState == pfds_pkg::PFDS_TX_ON; endsequence
  property p_refuse;
    txReqValid && txReqReady && trxState != pfds_pkg::PFDS_TX_ON
      |=> txConfirm && txStatus == (($past(trxState) == pfds_pkg::PFDS_RX_ON) ? 4'h6 : 4'h8);
  endproperty
  a_refuse: assert property (p_refuse) else $error("refused request confirm wrong");
  property p_pre; s_acc |=> lineTxValid && lineTxData == 8'hAA; endproperty
  a_pre: assert property (p_pre) else $error("frame did not open with preamble");
  // bound leaves room for a full frame under line stalls
  property p_done; s_acc |-> ##[4:900] (txConfirm && txStatus == 4'h7); endproperty
  a_done: assert property (p_done) else $error("no success confirm");
  property p_one; s_acc |=> !txConfirm [*3]; endproperty
  a_one: assert property (p_one) else $error("confirm before frame sent");
  property p_pulse; txConfirm |=> !txConfirm; endproperty
  a_pulse: assert property (p_pulse) else $error("confirm longer than one cycle");
  property p_stat; !txConfirm |=> txConfirm || $stable(txStatus); endproperty
  a_stat: assert property (p_stat) else $error("status moved without confirm");
  property p_lhold; lineTxValid && !lineTxReady |=> lineTxValid && $stable(lineTxData); endproperty
  a_lhold: assert property (p_lhold) else $error("line octet dropped under stall");
  property p_ind;
    lineRxStart && lineRxCount != 7'h00 && !rxIndValid
      |=> rxIndValid && rxOctetCount == $past(lineRxCount) && rxQualityValue == $past(lineRxQuality);
  endproperty
  a_ind: assert property (p_ind) else $error("indication wrong");
  property p_drop; lineRxStart && lineRxCount == 7'h00 && !rxIndValid |=> !rxIndValid [*3]; endproperty
  a_drop: assert property (p_drop) else $error("empty frame indicated");
  property p_rhold; rxOctetValid && !rxOctetReady |=> rxOctetValid && $stable(rxOctet); endproperty
  a_rhold: assert property (p_rhold) else $error("rx octet dropped under stall");
  c_ref: cover property (txConfirm && txStatus != 4'h7);
  c_ok: cover property (txConfirm && txStatus == 4'h7);
  c_ind: cover property (rxIndValid);
endmodule : pfds_checker

// >>> tb/pfds_mac_model.sv
// MAC-side payload source: octets seed, seed+0x25, ... for one frame
// assumes start is high on the edge that takes the request
`timescale 1ns/1ps
module pfds_mac_model (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       start,
  input  wire logic       slow,
  input  wire logic [6:0] count,
  input  wire logic [7:0] seed,
  output logic [7:0]      txOctet,
  output logic            txOctetValid,
  input  wire logic       txOctetReady
);
  // ****************
  // payload source
  // ****************
  logic [6:0] left;
  logic [7:0] cur;
  // held until taken; a released line shows the inverse so a stale octet never reads as good
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      left <= 7'h00;
      cur <= 8'h00;
      txOctetValid <= 1'b0;
      txOctet <= 8'h00;
    end else if (start) begin
      left <= count;
      cur <= seed;
      txOctetValid <= (count != 7'h00);
      txOctet <= seed;
    end else if (txOctetValid && txOctetReady) begin
      left <= left - 7'h01;
      cur <= cur + 8'h25;
      txOctetValid <= (left > 7'h01) && !slow;
      txOctet <= ((left > 7'h01) && !slow) ? cur + 8'h25 : ~txOctet;
    end else if (!txOctetValid && left != 7'h00) begin // slow mode resumes after a gap
      txOctetValid <= 1'b1;
      txOctet <= cur;
    end
  end
endmodule : pfds_mac_model

// >>> tb/tb.sv
// self-checking bench for the frame data service
// assumes the MAC model feeds payload; the bench plays control and line sides
`timescale 1ns/1ps
module tb;
  // ****************
  // signals
  // ****************
  logic clk = 1'b0, sys_rst = 1'b1, txReqValid = 1'b0, lineTxReady = 1'b0, lineRxStart = 1'b0;
  logic lineRxValid = 1'b0, rxIndReady = 1'b0, rxOctetReady = 1'b0, macStart = 1'b0, macSlow = 1'b0;
  logic [2:0] colorBandSelect = 3'h0;
  logic [6:0] frameOctetCount = 7'h00, lineRxCount = 7'h00;
  logic [7:0] lineRxQuality = 8'h00, lineRxData = 8'h00, macSeed = 8'h00;
  logic [15:0] rnd = 16'hA2A6, stl = 16'hA2A6; // both start at 41638
  pfds_pkg::pfds_trx_t trxState = pfds_pkg::PFDS_XCVR_OFF;
  logic txReqReady, txOctetValid, txOctetReady, txConfirm, lineTxValid, lineTxBusy, lineRxReady;
  logic rxIndValid, rxOctetValid;
  logic [2:0] lineColorBand;
  logic [6:0] rxOctetCount;
  logic [7:0] txOctet, lineTxData, rxQualityValue, rxOctet;
  pfds_pkg::pfds_status_t txStatus;
  logic [15:0] lineQ[$], statQ[$], indQ[$], rxQ[$];
  int fail_count = 0, cmp_count = 0, hold = 0;
  pfds_frame_data_service dut_u (.clk, .sys_rst, .trxState, .txReqValid, .txReqReady, .frameOctetCount,
    .colorBandSelect, .txOctet, .txOctetValid, .txOctetReady, .txConfirm, .txStatus, .lineTxData, .lineTxValid,
    .lineTxReady, .lineColorBand, .lineTxBusy, .lineRxStart, .lineRxCount, .lineRxQuality, .lineRxData,
    .lineRxValid, .lineRxReady, .rxIndValid, .rxIndReady, .rxOctetCount, .rxQualityValue, .rxOctet,
    .rxOctetValid, .rxOctetReady);
  pfds_mac_model mac_u (.clk, .sys_rst, .start(macStart), .slow(macSlow), .count(frameOctetCount),
    .seed(macSeed), .txOctet, .txOctetValid, .txOctetReady);
  always #5 clk = ~clk;
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next
  function automatic logic rdy(input int w);
    case (w)
      0: rdy = txReqReady;
      1: rdy = lineRxReady;
      2: rdy = txConfirm;
      default: rdy = (rxQ.size() == 0) && (indQ.size() == 0) && !rxOctetValid && !rxIndValid;
    endcase
  endfunction : rdy
  task automatic tally_and_finish();
    if (fail_count == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // bounded wait on an edge-sampled condition; running out ends the run
  task automatic wait_for(input int w);
    int t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (rdy(w) !== 1'b1 && t < 1000);
    if (rdy(w) !== 1'b1) begin
      fail_count++;
      tally_and_finish();
    end
  endtask : wait_for
  // one transmit request; the next may only start in the cycle after the confirm
  task automatic tx_req(input pfds_pkg::pfds_trx_t st, input logic [6:0] n);
    logic [2:0] b;
    rnd = lfsr_next(rnd);
    b = (rnd[10:8] == 3'h7) ? 3'h0 : rnd[10:8];
    trxState = st;
    txReqValid = 1'b1;
    frameOctetCount = n;
    colorBandSelect = b;
    macSeed = rnd[7:0];
    macSlow = rnd[11];
    macStart = (st == pfds_pkg::PFDS_TX_ON);
    if (!macStart) statQ.push_back((st == pfds_pkg::PFDS_RX_ON) ? 16'h0006 : 16'h0008);
    else begin
      statQ.push_back(16'h0007);
      lineQ.push_back(16'h00AA);
      lineQ.push_back({9'h000, n});
      for (int i = 0; i < n; i++) lineQ.push_back({8'h00, rnd[7:0] + 8'(i) * 8'h25});
    end
    wait_for(0);
    #1;
    txReqValid = 1'b0;
    macStart = 1'b0;
    check({15'h0000, lineTxBusy}, {15'h0000, st == pfds_pkg::PFDS_TX_ON});
    wait_for(2);
    if (st == pfds_pkg::PFDS_TX_ON) check({13'h0000, lineColorBand}, {13'h0000, b});
    check({15'h0000, lineTxBusy}, 16'h0000);
    #1;
  endtask : tx_req
  // one received frame from the line, octets held until taken
  task automatic rx_frame(input logic [6:0] n);
    #1; // step off the edge at which the last wait ended
    rnd = lfsr_next(rnd);
    lineRxStart = 1'b1;
    lineRxCount = n;
    lineRxQuality = rnd[15:8];
    if (n != 7'h00) indQ.push_back({1'b0, n, rnd[15:8]});
    @(posedge clk);
    #1;
    lineRxStart = 1'b0;
    for (int i = 0; i < n; i++) begin
      lineRxData = rnd[7:0] + 8'(i) * 8'h25;
      lineRxValid = 1'b1;
      rxQ.push_back({8'h00, lineRxData});
      wait_for(1);
      #1;
    end
    lineRxValid = 1'b0;
    lineRxData = ~lineRxData;
    repeat (4) @(posedge clk);
  endtask : rx_frame
  // far-side stalls; a long hold lets the rx buffer fill and refuse
  always @(posedge clk) begin
    #1;
    stl = lfsr_next(stl);
    lineTxReady = stl[0] | stl[1];
    rxIndReady = stl[2] | stl[4];
    rxOctetReady = (hold == 0) && (stl[3] | stl[5]);
    if (hold > 0) hold--;
  end
  // compare each result as it leaves against the oldest note
  always @(posedge clk) begin
    if (!sys_rst && lineTxValid && lineTxReady) check({8'h00, lineTxData}, lineQ.pop_front());
    if (!sys_rst && txConfirm) check({12'h000, txStatus}, statQ.pop_front());
    if (!sys_rst && rxIndValid && rxIndReady) check({1'b0, rxOctetCount, rxQualityValue}, indQ.pop_front());
    if (!sys_rst && rxOctetValid && rxOctetReady) check({8'h00, rxOctet}, rxQ.pop_front());
  end
  // main sequence: transmit and receive traffic run side by side
  initial begin
    repeat (2) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    fork
      for (int i = 0; i < 10; i++) begin
        rnd = lfsr_next(rnd);
        if (i < 3) tx_req(pfds_pkg::pfds_trx_t'(2'(i)), (i == 2) ? 7'h00 : 7'h05);
        else tx_req((i == 3 || rnd[1:0] == 2'h3) ? pfds_pkg::PFDS_TX_ON : pfds_pkg::pfds_trx_t'(rnd[1:0]),
                     (i == 3) ? 7'h7F : {2'h0, rnd[6:2]});
      end
      for (int j = 0; j < 6; j++) begin
        wait_for(3);
        if (j == 1) hold = 40;
        rx_frame((j == 0) ? 7'h00 : (j == 1) ? 7'h7F : {1'b0, rnd[5:0]});
      end
    join
    wait_for(3);
    check(16'(lineQ.size() + statQ.size()), 16'h0000);
    tally_and_finish();
  end
endmodule : tb
bind pfds_frame_data_service pfds_checker chk_u (.clk, .sys_rst, .trxState, .txReqValid, .txReqReady,
  .txConfirm, .txStatus, .lineTxData, .lineTxValid, .lineTxReady, .lineRxStart, .lineRxCount, .lineRxQuality,
  .rxIndValid, .rxOctetCount, .rxQualityValue, .rxOctet, .rxOctetValid, .rxOctetReady);
